// ---- hdl/rtc_trigger_ctrl.sv ----
// Purpose : Value supervision and trigger qualification for a recorder
// Assumes : Analog samples arrive on pclk; status pins are asynchronous
// Notes   : Zero-wait APB slave; read data is prepared in the setup cycle
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/100ps
// Behaviour
// - Reads always allowed; mode switch bit selects setting or measuring mode.
// - Instant values read back scaled by the rated current or voltage factor.
// - Maxima and minima of every channel tracked continuously with time tags.
// - A phase group captures all phases when any one phase hits an extreme.
// - Extreme write loads all phases of the group and clears its time tag.
// - Status keeps only latest change time; any write clears it.
// - Recording needs measuring mode, memory, trigger, permit bit, nonzero length.
// - Analog levels compare directly against scaled current and voltage values.
// - Status trigger enables held in one binary word, one bit per signal.
// - Edge select bit 0 means falling edge, 1 means rising edge.
// - Channel 1 is the leftmost (most significant) edge select bit.
// - Writing the period loads and starts the seconds countdown.
// - Countdown at one fires periodic trigger on the next second and reloads from period.
// - Countdown readable; a write overwrites the running count.
// - Period zero never produces a periodic trigger.
// - Permit mask bit n enables trigger source n, weight two to the n.
module rtc_trigger_ctrl
   import rtc_pkg::*;
#(
   parameter int unsigned SEC_CYC = SEC_CYCLES
) (
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [AW-1:0]         paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Measurement inputs
   input  wire logic [N_AN-1:0][VW-1:0] an_raw,
   input  wire logic [N_ST-1:0]       status_pin,
   input  wire logic                  ext_trig_pin,
   input  wire logic                  mem_free_pin,
   // Recorder control
   output logic                       rec_start,
   output logic      [N_TRG-1:0]      rec_cause,
   output logic                       setting_mode
);
   // ==========================================================
   // Decoding helpers
   function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] base,
                                input int unsigned n);
      return (a >= base) && (a < base + AW'(4 * n)) && (a[1:0] == 2'b00);
   endfunction : hit

   function automatic int unsigned idx(input logic [AW-1:0] a, input logic [AW-1:0] base);
      return int'((a - base) >> 2);
   endfunction : idx

   // Channels 0..2 phase currents, 3 neutral, 4..6 line voltages, 7 residual
   function automatic int unsigned grp(input int unsigned c);
      return (c < 3) ? 0 : (c == 3) ? 1 : (c < 7) ? 2 : 3;
   endfunction : grp

   // ==========================================================
   // State
   logic [31:0]             rdata_ff, nxt_rdata;
   logic                    ready_ff;
   logic                    err_ff,   nxt_err;
   logic                    setm_ff,  nxt_setm;
   logic [15:0]             rsi_ff,   nxt_rsi;
   logic [15:0]             rsv_ff,   nxt_rsv;
   logic [N_TRG-1:0]        perm_ff,  nxt_perm;
   logic [N_ST-1:0]         sten_ff,  nxt_sten;
   logic [N_ST-1:0]         edge_ff,  nxt_edge;
   logic [VW-1:0]           lvl_ff    [N_LVL];
   logic [VW-1:0]           nxt_lvl   [N_LVL];
   logic [7:0]              len_ff    [N_TRG];
   logic [7:0]              nxt_len   [N_TRG];
   logic [VW-1:0]           max_ff    [N_AN];
   logic [VW-1:0]           nxt_max   [N_AN];
   logic [VW-1:0]           min_ff    [N_AN];
   logic [VW-1:0]           nxt_min   [N_AN];
   logic [31:0]             tmax_ff   [N_GRP];
   logic [31:0]             nxt_tmax  [N_GRP];
   logic [31:0]             tmin_ff   [N_GRP];
   logic [31:0]             nxt_tmin  [N_GRP];
   logic [31:0]             time_ff,  nxt_time;
   logic [31:0]             stime_ff, nxt_stime;
   logic [N_LVL-1:0]        acond_ff;
   logic [N_ST+1:0]         sync1_ff, sync2_ff, sync3_ff;
   logic [N_ST+1:0]         pin_ff,   nxt_pin;
   logic                    start_ff, nxt_start;
   logic [N_TRG-1:0]        cause_ff, nxt_cause;

   logic [VW-1:0]           scaled    [N_AN];
   logic [N_LVL-1:0]        acond;
   logic [N_TRG-1:0]        trig;
   logic [N_TRG-1:0]        qual;
   logic [N_GRP-1:0]        gmax, gmin;
   logic                    setup, wr_en;

   rtc_timer_if tif ();

   rtc_period_timer #(.SEC_CYC(SEC_CYC)) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .tif     (tif)
   );

   // ==========================================================
   // Scaling to rated values
   genvar gc;
   generate
      for (gc = 0; gc < N_AN; gc++) begin : g_scale
         logic [31:0] prod;
         assign prod = an_raw[gc] * ((gc < N_CUR) ? rsi_ff : rsv_ff);
         assign scaled[gc] = prod[SCALE_SHIFT +: VW];
      end
   endgenerate

   // ==========================================================
   // Trigger sources
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite && ready_ff;

   always_comb begin
      // Analog levels, held in scaled units
      acond[0] = (scaled[0] > lvl_ff[0]) || (scaled[1] > lvl_ff[0])
                 || (scaled[2] > lvl_ff[0]);
      acond[1] = scaled[7] > lvl_ff[1];
      acond[2] = scaled[3] > lvl_ff[2];
      acond[3] = (scaled[4] > lvl_ff[3]) || (scaled[5] > lvl_ff[3])
                 || (scaled[6] > lvl_ff[3]);
      acond[4] = (scaled[4] < lvl_ff[4]) || (scaled[5] < lvl_ff[4])
                 || (scaled[6] < lvl_ff[4]);
      // A pin level is taken only once the last two stages agree, so a glitch is dropped
      nxt_pin = (sync2_ff & sync3_ff) | (pin_ff & (sync2_ff | sync3_ff));
      trig = '0;
      // Only the onset counts, so a standing fault starts one recording
      trig[N_LVL-1:0] = acond & ~acond_ff;
      for (int s = 0; s < N_ST; s++) begin
         // Channel 1 sits in the most significant bit
         trig[TRG_STAT0 + s] = sten_ff[N_ST-1-s] && (nxt_pin[s] != pin_ff[s])
                               && (nxt_pin[s] == edge_ff[N_ST-1-s]);
      end
      trig[TRG_EXT]      = nxt_pin[N_ST] && !pin_ff[N_ST];
      trig[TRG_PERIODIC] = tif.fire;
      for (int t = 0; t < N_TRG; t++) begin
         qual[t] = trig[t] && perm_ff[t] && (len_ff[t] != '0);
      end
      nxt_start = !setm_ff && pin_ff[N_ST+1] && (qual != '0);
      nxt_cause = nxt_start ? qual : cause_ff;
   end

   // ==========================================================
   // Register file and extreme tracking
   always_comb begin
      nxt_rdata = rdata_ff;
      nxt_err   = 1'b0;
      nxt_setm  = setm_ff;
      nxt_rsi   = rsi_ff;
      nxt_rsv   = rsv_ff;
      nxt_perm  = perm_ff;
      nxt_sten  = sten_ff;
      nxt_edge  = edge_ff;
      nxt_lvl   = lvl_ff;
      nxt_len   = len_ff;
      nxt_max   = max_ff;
      nxt_min   = min_ff;
      nxt_tmax  = tmax_ff;
      nxt_tmin  = tmin_ff;
      nxt_time  = tif.sec_stb ? time_ff + 32'h0000_0001 : time_ff;
      nxt_stime = stime_ff;
      tif.period_wr = 1'b0;
      tif.count_wr  = 1'b0;
      tif.wdata     = pwdata;
      for (int g = 0; g < N_GRP; g++) begin
         gmax[g] = 1'b0;
         gmin[g] = 1'b0;
      end
      for (int c = 0; c < N_AN; c++) begin
         if (scaled[c] > max_ff[c]) gmax[grp(c)] = 1'b1;
         if (scaled[c] < min_ff[c]) gmin[grp(c)] = 1'b1;
      end
      for (int c = 0; c < N_AN; c++) begin
         if (gmax[grp(c)]) nxt_max[c] = scaled[c];
         if (gmin[grp(c)]) nxt_min[c] = scaled[c];
      end
      for (int g = 0; g < N_GRP; g++) begin
         if (gmax[g]) nxt_tmax[g] = time_ff;
         if (gmin[g]) nxt_tmin[g] = time_ff;
      end
      // Reads are served in any mode; data is latched in the setup cycle
      if (setup) begin
         nxt_rdata = '0;
         if (paddr == A_CTRL)             nxt_rdata[CTRL_SET_BIT] = setm_ff;
         else if (paddr == A_RATED_I)     nxt_rdata[15:0] = rsi_ff;
         else if (paddr == A_RATED_V)     nxt_rdata[15:0] = rsv_ff;
         else if (paddr == A_PERMIT)      nxt_rdata[N_TRG-1:0] = perm_ff;
         else if (paddr == A_STAT_EN)     nxt_rdata[N_ST-1:0] = sten_ff;
         else if (paddr == A_EDGE_SEL)    nxt_rdata[N_ST-1:0] = edge_ff;
         else if (paddr == A_PERIOD)      nxt_rdata = tif.period;
         else if (paddr == A_COUNTDOWN)   nxt_rdata = tif.count;
         else if (paddr == A_STAT_INST)   nxt_rdata[N_ST-1:0] = pin_ff[N_ST-1:0];
         else if (paddr == A_STAT_TIME)   nxt_rdata = stime_ff;
         else if (hit(paddr, A_INST, N_AN))  nxt_rdata[VW-1:0] = scaled[idx(paddr, A_INST)];
         else if (hit(paddr, A_LVL, N_LVL))  nxt_rdata[VW-1:0] = lvl_ff[idx(paddr, A_LVL)];
         else if (hit(paddr, A_MAX, N_AN))   nxt_rdata[VW-1:0] = max_ff[idx(paddr, A_MAX)];
         else if (hit(paddr, A_MIN, N_AN))   nxt_rdata[VW-1:0] = min_ff[idx(paddr, A_MIN)];
         else if (hit(paddr, A_TMAX, N_GRP)) nxt_rdata = tmax_ff[idx(paddr, A_TMAX)];
         else if (hit(paddr, A_TMIN, N_GRP)) nxt_rdata = tmin_ff[idx(paddr, A_TMIN)];
         else if (hit(paddr, A_RECLEN, N_TRG)) nxt_rdata[7:0] = len_ff[idx(paddr, A_RECLEN)];
         else nxt_err = 1'b1;
      end else if (psel && penable) begin
         nxt_err = err_ff;
      end
      if (wr_en && !err_ff) begin
         if (paddr == A_CTRL)             nxt_setm = pwdata[CTRL_SET_BIT];
         else if (paddr == A_RATED_I)     nxt_rsi  = pwdata[15:0];
         else if (paddr == A_RATED_V)     nxt_rsv  = pwdata[15:0];
         else if (paddr == A_PERMIT)      nxt_perm = pwdata[N_TRG-1:0];
         else if (paddr == A_STAT_EN)     nxt_sten = pwdata[N_ST-1:0];
         else if (paddr == A_EDGE_SEL)    nxt_edge = pwdata[N_ST-1:0];
         else if (paddr == A_PERIOD)      tif.period_wr = 1'b1;
         else if (paddr == A_COUNTDOWN)   tif.count_wr  = 1'b1;
         else if (paddr == A_STAT_TIME)   nxt_stime = '0;
         else if (hit(paddr, A_LVL, N_LVL))    nxt_lvl[idx(paddr, A_LVL)] = pwdata[VW-1:0];
         else if (hit(paddr, A_RECLEN, N_TRG)) nxt_len[idx(paddr, A_RECLEN)] = pwdata[7:0];
         else if (hit(paddr, A_MAX, N_AN)) begin
            for (int c = 0; c < N_AN; c++) begin
               if (grp(c) == grp(idx(paddr, A_MAX))) nxt_max[c] = pwdata[VW-1:0];
            end
            nxt_tmax[grp(idx(paddr, A_MAX))] = '0;
         end else if (hit(paddr, A_MIN, N_AN)) begin
            for (int c = 0; c < N_AN; c++) begin
               if (grp(c) == grp(idx(paddr, A_MIN))) nxt_min[c] = pwdata[VW-1:0];
            end
            nxt_tmin[grp(idx(paddr, A_MIN))] = '0;
         end
      end
      // A change in the same cycle as a clear wins, so no change goes unrecorded
      if (nxt_pin[N_ST-1:0] != pin_ff[N_ST-1:0]) nxt_stime = time_ff;
   end

   // ==========================================================
   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_ff <= '0;
         ready_ff <= 1'b0;
         err_ff   <= 1'b0;
         setm_ff  <= 1'b0;
         rsi_ff   <= SCALE_RST;
         rsv_ff   <= SCALE_RST;
         perm_ff  <= PERMIT_RST;
         sten_ff  <= '0;
         edge_ff  <= '0;
         time_ff  <= '0;
         stime_ff <= '0;
         acond_ff <= '0;
         sync1_ff <= '0;
         sync2_ff <= '0;
         sync3_ff <= '0;
         pin_ff   <= '0;
         start_ff <= 1'b0;
         cause_ff <= '0;
         for (int i = 0; i < N_LVL; i++) lvl_ff[i] <= '0;
         for (int i = 0; i < N_TRG; i++) len_ff[i] <= '0;
         for (int i = 0; i < N_AN; i++) begin
            max_ff[i] <= '0;
            min_ff[i] <= MIN_RST;
         end
         for (int i = 0; i < N_GRP; i++) begin
            tmax_ff[i] <= '0;
            tmin_ff[i] <= '0;
         end
      end else begin
         rdata_ff <= nxt_rdata;
         ready_ff <= 1'b1;
         err_ff   <= nxt_err;
         setm_ff  <= nxt_setm;
         rsi_ff   <= nxt_rsi;
         rsv_ff   <= nxt_rsv;
         perm_ff  <= nxt_perm;
         sten_ff  <= nxt_sten;
         edge_ff  <= nxt_edge;
         time_ff  <= nxt_time;
         stime_ff <= nxt_stime;
         acond_ff <= acond;
         sync1_ff <= {mem_free_pin, ext_trig_pin, status_pin};
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         pin_ff   <= nxt_pin;
         start_ff <= nxt_start;
         cause_ff <= nxt_cause;
         lvl_ff   <= nxt_lvl;
         len_ff   <= nxt_len;
         max_ff   <= nxt_max;
         min_ff   <= nxt_min;
         tmax_ff  <= nxt_tmax;
         tmin_ff  <= nxt_tmin;
      end
   end

   assign prdata       = rdata_ff;
   assign pready       = ready_ff;
   assign pslverr      = err_ff;
   assign rec_start    = start_ff;
   assign rec_cause    = cause_ff;
   assign setting_mode = setm_ff;
endmodule : rtc_trigger_ctrl

// ---- hdl/rtc_pkg.sv ----
// Purpose : Shared constants for the recorder trigger control block
// Assumes : APB with 32-bit data, 40 MHz pclk
// Notes   : All offsets are byte addresses
package rtc_pkg;
   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned SECOND_S      = 1;
   localparam int unsigned SEC_CYCLES    = CLK_HZ * SECOND_S;
   // ==========================================================
   // Widths
   localparam int unsigned AW            = 12;
   localparam int unsigned VW            = 16;
   localparam int unsigned N_AN          = 8;
   localparam int unsigned N_ST          = 8;
   localparam int unsigned N_LVL         = 5;
   localparam int unsigned N_TRG         = 16;
   localparam int unsigned N_GRP         = 4;
   localparam int unsigned SCALE_SHIFT   = 8;
   // ==========================================================
   // Register map
   localparam logic [11:0] A_CTRL        = 12'h000;
   localparam logic [11:0] A_RATED_I     = 12'h004;
   localparam logic [11:0] A_RATED_V     = 12'h008;
   localparam logic [11:0] A_PERMIT      = 12'h00c;
   localparam logic [11:0] A_STAT_EN     = 12'h010;
   localparam logic [11:0] A_EDGE_SEL    = 12'h014;
   localparam logic [11:0] A_PERIOD      = 12'h018;
   localparam logic [11:0] A_COUNTDOWN   = 12'h01c;
   localparam logic [11:0] A_STAT_INST   = 12'h020;
   localparam logic [11:0] A_STAT_TIME   = 12'h024;
   localparam logic [11:0] A_INST        = 12'h040;
   localparam logic [11:0] A_LVL         = 12'h060;
   localparam logic [11:0] A_MAX         = 12'h080;
   localparam logic [11:0] A_MIN         = 12'h0a0;
   localparam logic [11:0] A_TMAX        = 12'h0c0;
   localparam logic [11:0] A_TMIN        = 12'h0d0;
   localparam logic [11:0] A_RECLEN      = 12'h100;
   // ==========================================================
   // Reset values and fields
   localparam logic [15:0] SCALE_RST     = 16'h0100;
   localparam logic [15:0] PERMIT_RST    = 16'hffff;
   localparam logic [15:0] MIN_RST       = 16'hffff;
   localparam int unsigned CTRL_SET_BIT  = 0;
   localparam int unsigned TRG_STAT0     = 5;
   localparam int unsigned TRG_EXT       = 13;
   localparam int unsigned TRG_PERIODIC  = 15;
   localparam int unsigned N_CUR         = 4;
endpackage : rtc_pkg

// ---- hdl/rtc_timer_if.sv ----
// Purpose : Carrier between register file and periodic countdown
// Assumes : Single pclk domain
// Notes   : Strobes are one cycle wide
`timescale 1ns/100ps
interface rtc_timer_if;
   logic        period_wr;
   logic        count_wr;
   logic [31:0] wdata;
   logic [31:0] period;
   logic [31:0] count;
   logic        sec_stb;
   logic        fire;
   modport regs  (output period_wr, count_wr, wdata, input period, count, sec_stb, fire);
   modport timer (input period_wr, count_wr, wdata, output period, count, sec_stb, fire);
endinterface : rtc_timer_if

// ---- hdl/rtc_period_timer.sv ----
// Purpose : Seconds prescaler and periodic countdown trigger
// Assumes : pclk at CLK_HZ
// Notes   : Period 0 disables the periodic trigger
`timescale 1ns/100ps
module rtc_period_timer
   import rtc_pkg::*;
#(
   parameter int unsigned SEC_CYC = SEC_CYCLES
) (
   // Clock and reset
   input wire logic  pclk,
   input wire logic  presetn,
   // Register side
   rtc_timer_if.timer tif
);
   logic [31:0] pre_ff,    nxt_pre;
   logic        stb_ff,    nxt_stb;
   logic [31:0] period_ff, nxt_period;
   logic [31:0] count_ff,  nxt_count;
   logic        fire_ff,   nxt_fire;

   always_comb begin
      nxt_pre    = pre_ff + 32'h0000_0001;
      nxt_stb    = 1'b0;
      nxt_period = period_ff;
      nxt_count  = count_ff;
      nxt_fire   = 1'b0;
      if (pre_ff == SEC_CYC - 1) begin
         nxt_pre = '0;
         nxt_stb = 1'b1;
      end
      if (tif.period_wr) begin
         nxt_period = tif.wdata;
         nxt_count  = tif.wdata;
      end else if (tif.count_wr) begin
         nxt_count = tif.wdata;
      end else if (stb_ff) begin
         if (count_ff > 32'h0000_0001) begin
            nxt_count = count_ff - 32'h0000_0001;
         end else if (period_ff != '0) begin
            nxt_fire  = 1'b1;
            nxt_count = period_ff;
         end else begin
            nxt_count = '0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_ff    <= '0;
         stb_ff    <= 1'b0;
         period_ff <= '0;
         count_ff  <= '0;
         fire_ff   <= 1'b0;
      end else begin
         pre_ff    <= nxt_pre;
         stb_ff    <= nxt_stb;
         period_ff <= nxt_period;
         count_ff  <= nxt_count;
         fire_ff   <= nxt_fire;
      end
   end

   assign tif.period  = period_ff;
   assign tif.count   = count_ff;
   assign tif.sec_stb = stb_ff;
   assign tif.fire    = fire_ff;
endmodule : rtc_period_timer

// ---- tb/rtc_trigger_ctrl_assertions.sv ----
// Purpose : Port-level checks for the recorder trigger control block
// Assumes : Zero-wait APB slave, one pclk domain
// Notes   : Bound to every instance of the top module
`timescale 1ns/100ps
module rtc_trigger_ctrl_assertions
   import rtc_pkg::*;
#(
   parameter int unsigned SEC_CYC = SEC_CYCLES
) (
   // Clock and reset
   input wire logic                    pclk,
   input wire logic                    presetn,
   // APB
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [AW-1:0]           paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   // Measurement and recorder
   input wire logic [N_AN-1:0][VW-1:0] an_raw,
   input wire logic [N_ST-1:0]         status_pin,
   input wire logic                    ext_trig_pin,
   input wire logic                    mem_free_pin,
   input wire logic                    rec_start,
   input wire logic [N_TRG-1:0]        rec_cause,
   input wire logic                    setting_mode
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence access_at(logic [AW-1:0] a);
      psel && penable && paddr == a;
   endsequence
   sequence ctrl_write;
      access_at(A_CTRL) ##0 pwrite;
   endsequence
   ready_after_reset_a: assert property ($past(presetn) |-> pready)
      else $error("pready low outside reset");
   mode_follows_ctrl_a: assert property (ctrl_write |=> setting_mode == $past(pwdata[0]))
      else $error("mode bit did not follow control write");
   mapped_no_err_a: assert property (access_at(A_PERIOD) |-> !pslverr)
      else $error("error on mapped register");
   unmapped_err_a: assert property (access_at(12'h3fc) |-> pslverr)
      else $error("no error on unmapped address");
   start_pulse_a: assert property (rec_start |=> !rec_start)
      else $error("recording start wider than one cycle");
   start_meas_mode_a: assert property (rec_start |-> !$past(setting_mode))
      else $error("recording started in setting mode");
   start_cause_a: assert property (rec_start |-> rec_cause != '0 && !rec_cause[14])
      else $error("recording start with bad cause");
   cause_hold_a: assert property (!rec_start |-> $stable(rec_cause))
      else $error("cause changed without a start");
endmodule : rtc_trigger_ctrl_assertions
bind rtc_trigger_ctrl rtc_trigger_ctrl_assertions #(.SEC_CYC(SEC_CYC)) chk_i (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .an_raw,
   .status_pin, .ext_trig_pin, .mem_free_pin, .rec_start, .rec_cause, .setting_mode);

// ---- tb/rtc_host_model.sv ----
// Purpose : Host-side APB master standing in for the substation host
// Assumes : Slave answers with pready; no fixed latency is assumed
// Notes   : One idle cycle before every transfer keeps drivers race free
`timescale 1ns/100ps
module rtc_host_model
   import rtc_pkg::*;
(
   // Clock
   input  wire logic          pclk,
   // APB master side
   output logic               psel,
   output logic               penable,
   output logic               pwrite,
   output logic [AW-1:0]      paddr,
   output logic [31:0]        pwdata,
   input  wire logic [31:0]   prdata,
   input  wire logic          pready,
   input  wire logic          pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0000_0000;
   end
   // Writes go out in either mode; the bench writes without selecting setting mode first
   task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : rtc_host_model

// ---- tb/recorder_trigger_control_tb_top.sv ----
// Purpose : Self-checking bench for the recorder trigger control block
// Assumes : Seconds strobe shortened to SEC cycles
// Notes   : Each scenario task drives and judges on its own
`timescale 1ns/100ps
module recorder_trigger_control_tb_top;
   import rtc_pkg::*;
   localparam int unsigned SEC = 20;
   logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [AW-1:0]           paddr;
   logic [31:0]             pwdata, prdata, q;
   logic [N_AN-1:0][VW-1:0] an_raw;
   logic [N_ST-1:0]         status_pin;
   logic                    ext_trig_pin, mem_free_pin, rec_start, setting_mode, e;
   logic [N_TRG-1:0]        rec_cause;
   int                      errors, n_tests;
   rtc_trigger_ctrl #(.SEC_CYC(SEC)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .an_raw, .status_pin, .ext_trig_pin,
      .mem_free_pin, .rec_start, .rec_cause, .setting_mode);
   rtc_host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr);
   // ==========================================================
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input string nm, input logic [AW-1:0] a, input logic [31:0] exp);
      host.xfer(1'b0, a, 32'h0000_0000, q, e);
      chk(nm, q, exp);
   endtask : rd
   // Start is a one-cycle pulse, so every cycle of the span is looked at
   task automatic see_start(input string nm, input int span, input logic [N_TRG-1:0] exp);
      logic hit;
      logic [N_TRG-1:0] c;
      hit = 1'b0;
      c = '0;
      repeat (span) begin
         @(posedge pclk);
         if (rec_start === 1'b1 && !hit) begin
            hit = 1'b1;
            c = rec_cause;
         end
      end
      chk(nm, 32'({hit, c}), 32'({exp != '0, exp}));
   endtask : see_start
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      rd("rated_i", A_RATED_I, 32'h0000_0100);
      rd("permit", A_PERMIT, 32'h0000_ffff);
      rd("min0", A_MIN, 32'h0000_0000);
      rd("count", A_COUNTDOWN, 32'h0000_0000);
      host.xfer(1'b0, 12'h3fc, 32'h0000_0000, q, e);
      chk("unmapped", 32'(e), 32'h0000_0001);
   endtask : t_reset
   task automatic t_gates;
      wr(A_RECLEN + 12'h034, 32'h0000_0001);
      wr(A_CTRL, 32'h0000_0001);
      rd("ctrl", A_CTRL, 32'h0000_0001);
      ext_trig_pin <= 1'b1;
      see_start("set_mode", 12, '0);
      ext_trig_pin <= 1'b0;
      wr(A_CTRL, 32'h0000_0000);
      ext_trig_pin <= 1'b1;
      see_start("ext", 12, 16'h2000);
      ext_trig_pin <= 1'b0;
      mem_free_pin <= 1'b0;
      repeat (3) @(posedge pclk);
      ext_trig_pin <= 1'b1;
      see_start("no_mem", 12, '0);
      ext_trig_pin <= 1'b0;
      mem_free_pin <= 1'b1;
      wr(A_RECLEN + 12'h034, 32'h0000_0000);
      ext_trig_pin <= 1'b1;
      see_start("len_zero", 12, '0);
      ext_trig_pin <= 1'b0;
   endtask : t_gates
   task automatic t_analog;
      an_raw[0] <= 16'h0200;
      an_raw[4] <= 16'h0100;
      wr(A_RATED_I, 32'h0000_0180);
      wr(A_RATED_V, 32'h0000_0200);
      rd("inst_i", A_INST, 32'h0000_0300);
      rd("inst_u", A_INST + 12'h010, 32'h0000_0200);
      wr(A_LVL, 32'h0000_0400);
      wr(A_RECLEN, 32'h0000_0001);
      an_raw[0] <= 16'h0300;
      an_raw[1] <= 16'h0080;
      see_start("over_i", 12, 16'h0001);
      rd("max_ph2", A_MAX + 12'h004, 32'h0000_00c0);
      wr(A_MAX + 12'h008, 32'h0000_0700);
      rd("max_ph1", A_MAX, 32'h0000_0700);
      rd("tmax_g0", A_TMAX, 32'h0000_0000);
   endtask : t_analog
   task automatic t_status;
      wr(A_STAT_EN, 32'h0000_0088);
      wr(A_EDGE_SEL, 32'h0000_000f);
      wr(A_RECLEN + 12'h014, 32'h0000_0001);
      wr(A_RECLEN + 12'h024, 32'h0000_0001);
      status_pin[0] <= 1'b1;
      see_start("ch1_rise", 12, '0);
      status_pin[0] <= 1'b0;
      see_start("ch1_fall", 12, 16'h0020);
      status_pin[4] <= 1'b1;
      see_start("ch5_rise", 12, 16'h0200);
      rd("stat_inst", A_STAT_INST, 32'h0000_0010);
      wr(A_STAT_TIME, 32'h0000_0001);
      rd("stat_time", A_STAT_TIME, 32'h0000_0000);
      wr(A_PERMIT, 32'h0000_ffdf);
      status_pin[0] <= 1'b1;
      repeat (10) @(posedge pclk);
      status_pin[0] <= 1'b0;
      see_start("masked", 12, '0);
      wr(A_PERMIT, 32'h0000_ffff);
   endtask : t_status
   task automatic t_periodic;
      wr(A_RECLEN + 12'h03c, 32'h0000_0001);
      wr(A_PERIOD, 32'h0000_0002);
      see_start("per_first", 3 * SEC + 10, 16'h8000);
      see_start("per_again", 2 * SEC + 10, 16'h8000);
      host.xfer(1'b1, A_COUNTDOWN, 32'h0000_0007, q, e);
      host.xfer(1'b0, A_COUNTDOWN, 32'h0000_0000, q, e);
      chk("count_wr", 32'(q == 32'h0000_0007 || q == 32'h0000_0006), 32'h0000_0001);
      wr(A_PERIOD, 32'h0000_0000);
      see_start("per_off", 10 * SEC, '0);
   endtask : t_periodic
   // ==========================================================
   // Clock, reset, sequence and watchdog
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   initial begin
      #(25 * 30000);
      errors++;
      wrap_up();
   end
   initial begin
      presetn = 1'b0;
      an_raw = '0;
      status_pin = '0;
      ext_trig_pin = 1'b0;
      mem_free_pin = 1'b1;
      errors = 0;
      n_tests = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_gates();
      t_analog();
      t_status();
      t_periodic();
      wrap_up();
   end
endmodule : recorder_trigger_control_tb_top
